/* include/sfr_pkg.sv */
// Purpose: constants and types for the supply rail fault response block
// Assumes: 40 MHz i_mclk, synchronous comparator inputs
// Notes:   one control byte, status byte at its own address
package sfr_pkg;

  ////////////////////////////////////////////////////////////////////////
  localparam logic [7:0]  SFR_ADDR_CTRL  = 8'hB3;
  localparam logic [7:0]  SFR_ADDR_STAT  = 8'hD3;
  localparam logic [7:0]  SFR_CTRL_RST   = 8'h00;
  localparam logic [7:0]  SFR_STAT_RST   = 8'h00;
  localparam int          SFR_NCOND      = 4;

  // field position of each condition in the response register
  localparam int          SFR_FLD_DRV_OV = 0;
  localparam int          SFR_FLD_DRV_UV = 2;
  localparam int          SFR_FLD_LOG_OV = 4;
  localparam int          SFR_FLD_LOG_UV = 6;

  // status bit of each condition
  localparam int          SFR_ST_LOG_OV  = 0;
  localparam int          SFR_ST_LOG_UV  = 1;
  localparam int          SFR_ST_DRV_OV  = 2;
  localparam int          SFR_ST_DRV_UV  = 4;

  // response field codes
  localparam logic [1:0]  SFR_RESP_FLAG  = 2'h0;
  localparam logic [1:0]  SFR_RESP_HICC  = 2'h1;
  localparam logic [1:0]  SFR_RESP_LATCH = 2'h2;
  localparam logic [1:0]  SFR_RESP_FLAG2 = 2'h3;

  localparam longint      SFR_CLK_HZ     = 40000000;
  localparam longint      SFR_HICCUP_MS  = 500;
  localparam longint      SFR_HICCUP_CYC = (SFR_HICCUP_MS * SFR_CLK_HZ) / 1000;
  localparam int          SFR_CNT_W      = 25;

  typedef enum logic [1:0] {
    SFR_HICCUP_NONE,
    SFR_HICCUP_STOP,
    SFR_LATCH_STOP
  } sfr_action_t;

  typedef struct packed {
    logic drv_ov;
    logic drv_uv;
    logic log_ov;
    logic log_uv;
  } sfr_faults_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sfr_reg_req_t;

  // 11 folds onto 00, unknown codes never stop switching
  function automatic sfr_action_t sfr_decode(input logic [1:0] code);
    sfr_action_t a;
    a = SFR_HICCUP_NONE;
    case (code)
      SFR_RESP_HICC:  a = SFR_HICCUP_STOP;
      SFR_RESP_LATCH: a = SFR_LATCH_STOP;
      default:        a = SFR_HICCUP_NONE;
    endcase
    return a;
  endfunction

endpackage

/* rtl/sfr_fault_resp.sv */
// Purpose: fault response register and PWM stop control for both rails
// Assumes: register port single cycle strobes, inputs synchronous
// Notes:   status bits are sticky, writing one at the status address clears
module sfr_fault_resp
  import sfr_pkg::*;
#(
  parameter logic [SFR_CNT_W-1:0] HICC_CY = SFR_CNT_W'(SFR_HICCUP_CYC)
) (
  input  wire logic         i_mclk,
  input  wire logic         i_sys_rst,
  input  wire logic         i_ce,
  input  wire sfr_reg_req_t i_reg_req,
  output logic [7:0]        o_reg_rdata,
  input  wire sfr_faults_t  i_faults,
  input  wire logic         i_indiv_resp_en,
  input  wire logic [1:0]   i_mode_resp,
  input  wire logic         i_pwm_en,
  input  wire logic         i_chip_en,
  output logic              o_pwm_stop,
  output logic [7:0]        o_status,
  output logic              o_fault_flag_n_o,
  output logic              o_fault_flag_n_oe
);

  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] stat;
    logic [7:0] rdata;
  } sfr_top_t;

  sfr_top_t    state_reg;
  sfr_top_t    state_next;
  logic [3:0]  cond;
  logic [3:0]  stop;
  logic [7:0]  set_mask;
  logic [7:0]  clr_mask;
  sfr_action_t act [SFR_NCOND];
  int          fld  [SFR_NCOND];

  ////////////////////////////////////////////////////////////////////////
  assign cond   = {i_faults.log_uv, i_faults.log_ov, i_faults.drv_uv, i_faults.drv_ov};
  assign fld[0] = SFR_FLD_DRV_OV;
  assign fld[1] = SFR_FLD_DRV_UV;
  assign fld[2] = SFR_FLD_LOG_OV;
  assign fld[3] = SFR_FLD_LOG_UV;

  always_comb begin
    for (int i = 0; i < SFR_NCOND; i++) begin
      // mode pin wins unless individual responses are enabled
      act[i] = i_indiv_resp_en ? sfr_decode(state_reg.ctrl[fld[i] +: 2])
                               : sfr_decode(i_mode_resp);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  for (genvar g = 0; g < SFR_NCOND; g++) begin : g_cell
    sfr_resp_cell #(
      .CNT_W   (SFR_CNT_W),
      .HICC_CY (HICC_CY)
    ) u_cell (
      .i_mclk    (i_mclk),
      .i_sys_rst (i_sys_rst),
      .i_ce      (i_ce),
      .i_fault   (cond[g]),
      .i_action  (act[g]),
      .i_run_en  (i_pwm_en & i_chip_en),
      .o_stop    (stop[g])
    );
  end

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    set_mask                = 8'h00;
    set_mask[SFR_ST_DRV_OV] = i_faults.drv_ov;
    set_mask[SFR_ST_DRV_UV] = i_faults.drv_uv;
    set_mask[SFR_ST_LOG_OV] = i_faults.log_ov;
    set_mask[SFR_ST_LOG_UV] = i_faults.log_uv;
    clr_mask = 8'h00;
    if (i_reg_req.wr && i_reg_req.addr == SFR_ADDR_STAT) begin
      clr_mask = i_reg_req.wdata;
    end
    state_next = state_reg;
    if (i_reg_req.wr && i_reg_req.addr == SFR_ADDR_CTRL) begin
      state_next.ctrl = i_reg_req.wdata;
    end
    // set beats a clear landing in the same cycle
    state_next.stat = (state_reg.stat & ~clr_mask) | set_mask;
    if (i_reg_req.rd) begin
      case (i_reg_req.addr)
        SFR_ADDR_CTRL: state_next.rdata = state_reg.ctrl;
        SFR_ADDR_STAT: state_next.rdata = state_reg.stat;
        default:       state_next.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state_reg <= '{ctrl: SFR_CTRL_RST, stat: SFR_STAT_RST, rdata: 8'h00};
    end else if (i_ce) begin
      state_reg <= state_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  assign o_reg_rdata       = state_reg.rdata;
  assign o_status          = state_reg.stat;
  assign o_pwm_stop        = |stop;
  // open drain: only ever pulls low
  assign o_fault_flag_n_o  = 1'b0;
  assign o_fault_flag_n_oe = |state_reg.stat;

endmodule

/* rtl/sfr_resp_cell.sv */
// Purpose: response sequencer for one supply rail condition
// Assumes: i_fault synchronous to i_mclk
// Notes:   restart from latch-off needs only i_run_en low, no return high
module sfr_resp_cell
  import sfr_pkg::*;
#(
  parameter int                   CNT_W   = SFR_CNT_W,
  parameter logic [SFR_CNT_W-1:0] HICC_CY = SFR_CNT_W'(SFR_HICCUP_CYC)
) (
  input  wire logic        i_mclk,
  input  wire logic        i_sys_rst,
  input  wire logic        i_ce,
  input  wire logic        i_fault,
  input  wire sfr_action_t i_action,
  input  wire logic        i_run_en,
  output logic             o_stop
);

  typedef enum logic [1:0] {
    SFR_C_RUN,
    SFR_C_HOLD,
    SFR_C_WAIT,
    SFR_C_LATCH
  } sfr_cell_st_t;

  typedef struct packed {
    sfr_cell_st_t     st;
    logic [CNT_W-1:0] cnt;
  } sfr_cell_t;

  sfr_cell_t state_reg;
  sfr_cell_t state_next;

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    state_next = state_reg;
    case (state_reg.st)
      SFR_C_RUN: begin
        if (i_fault && i_action == SFR_HICCUP_STOP) begin
          state_next.st = SFR_C_HOLD;
        end else if (i_fault && i_action == SFR_LATCH_STOP) begin
          state_next.st = SFR_C_LATCH;
        end
      end
      SFR_C_HOLD: begin
        // timer only starts once the comparator drops
        if (!i_fault) begin
          state_next.st  = SFR_C_WAIT;
          state_next.cnt = '0;
        end
      end
      SFR_C_WAIT: begin
        if (i_fault) begin
          state_next.st = SFR_C_HOLD;
        end else if (state_reg.cnt >= HICC_CY - CNT_W'(1)) begin
          state_next.st = SFR_C_RUN;
        end else begin
          state_next.cnt = state_reg.cnt + CNT_W'(1);
        end
      end
      SFR_C_LATCH: begin
        if (!i_run_en) begin
          state_next.st = SFR_C_RUN;
        end
      end
      default: state_next.st = SFR_C_RUN;
    endcase
  end

  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state_reg <= '{st: SFR_C_RUN, cnt: '0};
    end else if (i_ce) begin
      state_reg <= state_next;
    end
  end

  assign o_stop = (state_reg.st != SFR_C_RUN);

endmodule

/* testbench/sfr_fault_resp_sva.sv */
// Purpose: port checks for the supply rail fault response block
// Assumes: checks pause while i_ce is low
// Notes:   hiccup length is measured by the bench
module sfr_fault_resp_sva import sfr_pkg::*; (
  input wire logic        i_mclk,
  input wire logic        i_sys_rst,
  input wire logic        i_ce,
  input wire sfr_faults_t i_faults,
  input wire logic        i_indiv_resp_en,
  input wire logic [1:0]  i_mode_resp,
  input wire logic        i_pwm_en,
  input wire logic        i_chip_en,
  input wire logic        o_pwm_stop,
  input wire logic [7:0]  o_status,
  input wire logic        o_fault_flag_n_o,
  input wire logic        o_fault_flag_n_oe
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_sys_rst || !i_ce);
  ////////////////////////////////////////////////////////////////////////
  chk_flag_low: assert property (!o_fault_flag_n_o && o_fault_flag_n_oe == |o_status) else $error("flag state");
  chk_flag_oe: assert property (|i_faults |=> o_fault_flag_n_oe) else $error("flag idle");
  chk_st_dov: assert property (i_faults.drv_ov |=> o_status[SFR_ST_DRV_OV]) else $error("st dov");
  chk_st_duv: assert property (i_faults.drv_uv |=> o_status[SFR_ST_DRV_UV]) else $error("st duv");
  chk_st_lov: assert property (i_faults.log_ov |=> o_status[SFR_ST_LOG_OV]) else $error("st lov");
  chk_st_luv: assert property (i_faults.log_uv |=> o_status[SFR_ST_LOG_UV]) else $error("st luv");
  chk_flag_no_stop:
    assert property (!i_indiv_resp_en && i_mode_resp[1] == i_mode_resp[0] && !o_pwm_stop |=> !o_pwm_stop)
      else $error("flag code stop");
  chk_hiccup_held:
    assert property (!i_indiv_resp_en && i_mode_resp == SFR_RESP_HICC && |(i_faults & ~$past(i_faults))
      |=> o_pwm_stop [*8]) else $error("hiccup short");
  chk_latch_held:
    assert property (!i_indiv_resp_en && i_mode_resp == SFR_RESP_LATCH && |i_faults && i_pwm_en && i_chip_en
      |=> o_pwm_stop) else $error("latch no stop");
endmodule
bind sfr_fault_resp sfr_fault_resp_sva u_sfr_fault_resp_sva (.*);

/* testbench/sfr_fault_resp_tb_top.sv */
// Purpose: self-checking bench for the supply rail fault response block
// Assumes: 40 MHz clock, hiccup count cut to 20 cycles
// Notes:   i_ce dropped once, a fault and a write must both be ignored
module sfr_fault_resp_tb_top import sfr_pkg::*; ();
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [SFR_CNT_W-1:0] HC = 25'h14;
  logic         i_mclk, i_sys_rst, i_indiv_resp_en, i_pwm_en, i_chip_en;
  logic         i_ce = 1'b1;
  logic         o_pwm_stop, o_fault_flag_n_o, o_fault_flag_n_oe;
  logic [1:0]   i_mode_resp;
  logic [7:0]   o_reg_rdata, o_status, mctl;
  sfr_faults_t  i_faults;
  sfr_reg_req_t i_reg_req;
  logic [31:0]  seed = 32'h108A8;
  int           err_count, checked, cyc;
  int           sbit [4] = '{SFR_ST_DRV_OV, SFR_ST_DRV_UV, SFR_ST_LOG_OV, SFR_ST_LOG_UV};
  sfr_fault_resp #(
    .HICC_CY (HC)
  ) u_sfr_fault_resp (
    .i_mclk            (i_mclk),
    .i_sys_rst         (i_sys_rst),
    .i_ce              (i_ce),
    .i_reg_req         (i_reg_req),
    .o_reg_rdata       (o_reg_rdata),
    .i_faults          (i_faults),
    .i_indiv_resp_en   (i_indiv_resp_en),
    .i_mode_resp       (i_mode_resp),
    .i_pwm_en          (i_pwm_en),
    .i_chip_en         (i_chip_en),
    .o_pwm_stop        (o_pwm_stop),
    .o_status          (o_status),
    .o_fault_flag_n_o  (o_fault_flag_n_o),
    .o_fault_flag_n_oe (o_fault_flag_n_oe)
  );
  sfr_host_model host (.i_mclk(i_mclk), .i_rdata(o_reg_rdata), .o_req(i_reg_req), .o_pwm_en(i_pwm_en),
    .o_chip_en(i_chip_en));
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic complete_run();
    $display("checks=%0d errors=%0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // one condition at a time, so each stop is owed to one field, or to the mode pin while the enable is low
  task automatic run_case(input int c, input int k);
    logic [7:0] mst;
    logic [7:0] stp;
    mst = 8'h01 << sbit[c];
    stp = {7'h00, k == 1 || k == 2};
    i_faults = 4'h8 >> c;
    repeat (2) @(negedge i_mclk);
    chk(o_status, mst);
    chk({7'h00, o_fault_flag_n_oe}, 8'h01);
    chk({7'h00, o_pwm_stop}, stp);
    host.put(1'b0, SFR_ADDR_STAT, 8'h00);
    chk(o_reg_rdata, mst);
    i_faults = '0;
    repeat (HC) @(negedge i_mclk);
    chk({7'h00, o_pwm_stop}, stp);
    repeat (1) @(negedge i_mclk);
    chk({7'h00, o_pwm_stop}, {7'h00, k == 2});
    if (k == 2) host.restart(c[0]);
    chk({7'h00, o_pwm_stop}, 8'h00);
    host.put(1'b1, SFR_ADDR_STAT, 8'hFF);
    @(negedge i_mclk);
    chk({o_status[6:0], o_fault_flag_n_oe}, 8'h00);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    i_mclk = 1'b0;
    forever #12.5 i_mclk = ~i_mclk;
  end
  always @(posedge i_mclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_count++;
      complete_run();
    end
  end
  initial begin
    i_sys_rst = 1'b1;
    i_faults = '0;
    i_indiv_resp_en = 1'b0;
    i_mode_resp = 2'h0;
    repeat (10) @(negedge i_mclk);
    i_sys_rst = 1'b0;
    host.put(1'b0, SFR_ADDR_CTRL, 8'h00);
    chk(o_reg_rdata, SFR_CTRL_RST);
    chk(o_status, SFR_STAT_RST);
    for (int i = 0; i < 8; i++) begin
      seed = xs(seed);
      mctl = seed[7:0];
      host.put(1'b1, SFR_ADDR_CTRL, mctl);
      host.put(1'b0, i[0] ? SFR_ADDR_CTRL : 8'hB4, 8'h00);
      chk(o_reg_rdata, i[0] ? mctl : 8'h00);
    end
    // frozen: a latch-off fault and a control write must leave no trace
    i_ce = 1'b0;
    i_mode_resp = SFR_RESP_LATCH;
    i_faults = 4'h8;
    host.put(1'b1, SFR_ADDR_CTRL, ~mctl);
    chk(o_status, SFR_STAT_RST);
    chk({7'h00, o_fault_flag_n_oe}, 8'h00);
    chk({7'h00, o_pwm_stop}, 8'h00);
    i_faults = '0;
    i_ce = 1'b1;
    host.put(1'b0, SFR_ADDR_CTRL, 8'h00);
    chk(o_reg_rdata, mctl);
    // with the enable low the field holds a code of other behaviour
    for (int e = 0; e < 2; e++) begin
      for (int c = 0; c < 4; c++) begin
        for (int k = 0; k < 4; k++) begin
          seed = xs(seed);
          i_indiv_resp_en = e[0];
          i_mode_resp = e[0] ? seed[9:8] : k[1:0];
          mctl = seed[7:0] & ~(8'h03 << 2 * c) | (8'(e[0] ? k : k ^ 1) << 2 * c);
          host.put(1'b1, SFR_ADDR_CTRL, mctl);
          run_case(c, k);
        end
      end
    end
    complete_run();
  end
endmodule

/* testbench/sfr_host_model.sv */
// Purpose: system controller model on the register port
// Assumes: strobes launched on the falling edge
// Notes:   released address and data show the inverse of the last value
module sfr_host_model import sfr_pkg::*; (
  input  wire logic       i_mclk,
  input  wire logic [7:0] i_rdata,
  output sfr_reg_req_t    o_req,
  output logic            o_pwm_en,
  output logic            o_chip_en
);
  timeunit 1ns;
  timeprecision 100ps;
  initial o_req = '0;
  initial o_pwm_en = 1'b1;
  initial o_chip_en = 1'b1;
  ////////////////////////////////////////////////////////////////////////
  // read data is valid once this returns
  task automatic put(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(negedge i_mclk);
    o_req <= '{w, !w, a, d};
    @(negedge i_mclk);
    o_req <= '{1'b0, 1'b0, ~a, ~d};
  endtask
  // one enable low is enough to release a latch-off
  task automatic restart(input logic sel);
    @(negedge i_mclk);
    o_pwm_en <= sel;
    o_chip_en <= !sel;
    repeat (3) @(negedge i_mclk);
    o_pwm_en <= 1'b1;
    o_chip_en <= 1'b1;
    @(negedge i_mclk);
  endtask
endmodule
